// *** rtl/charger_id_pkg.sv ***
// package: offsets, field positions, reset values and timing for the charger/id register group
package charger_id_pkg;

    // ulpi immediate register command codes (bits 7:6 of the command byte)
    localparam logic [1:0] CMD_REG_WRITE = 2'h2;
    localparam logic [1:0] CMD_REG_READ = 2'h3;
    localparam int CMD_CODE_MSB = 7;
    localparam int CMD_CODE_LSB = 6;
    localparam int CMD_ADDR_MSB = 5;

    // register offsets
    localparam logic [5:0] VENDOR_FIRST = 6'h30;
    localparam logic [5:0] VENDOR_LAST = 6'h3f;
    localparam logic [5:0] CHARGER_DETECT_CONTROL = 6'h32;
    localparam logic [5:0] HEADSET_AUDIO_CONTROL = 6'h33;
    localparam logic [5:0] ID_RESISTOR_MEASURE = 6'h36;
    localparam logic [5:0] ID_RESISTOR_MEASURE_SET = 6'h37;
    localparam logic [5:0] ID_RESISTOR_MEASURE_CLR = 6'h38;

    // charger_detect_control fields
    localparam int DATA_VOLTAGE_SOURCE_EN_BIT = 0;
    localparam int DATA_SINK_COMPARATOR_EN_BIT = 1;
    localparam int DP_SOURCE_CURRENT_EN_BIT = 2;
    localparam int CHARGING_HOST_ROLE_BIT = 3;
    localparam int DATA_VOLTAGE_SEEN_BIT = 4;
    localparam int CHARGER_RW_MSB = 3;
    localparam logic [3:0] CHARGER_RESET = 4'h0;
    localparam logic [1:0] LINE_STATE_SE0 = 2'h0;

    // headset_audio_control fields
    localparam int AUDIO_KEY_MSB = 3;
    localparam logic [3:0] AUDIO_MODE_KEY = 4'ha;
    localparam logic [3:0] AUDIO_RESET = 4'h0;

    // id_resistor_measure fields
    localparam int ID_CODE_MSB = 2;
    localparam int ID_MEASURE_DONE_BIT = 3;
    localparam int ID_MEASURE_GO_BIT = 4;
    localparam int ID_RESERVED_BIT = 5;
    localparam int ID_DONE_IRQ_ENABLE_BIT = 6;
    localparam logic [2:0] ID_CODE_RESET = 3'h0;
    localparam logic [2:0] ID_CODE_ZERO_OHM = 3'h0;
    localparam logic [2:0] ID_CODE_75_OHM = 3'h1;
    localparam logic [2:0] ID_CODE_100_KOHM = 3'h2;
    localparam logic [2:0] ID_CODE_200_KOHM = 3'h3;
    localparam logic [2:0] ID_CODE_440_KOHM = 3'h4;
    localparam logic [2:0] ID_CODE_FLOATING = 3'h5;
    localparam logic [2:0] ID_CODE_ERROR = 3'h7;
    // writable/settable/clearable bits 6:4
    localparam logic [7:0] ID_SC_MASK = 8'h70;

    // rxcmd byte
    localparam int RXCMD_ALT_INT_BIT = 7;

    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int ID_MEASURE_TIME_NS = 282000;
    localparam int ID_MEASURE_CYCLES = (ID_MEASURE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // analog switch controls after the dp/dm role swap
    typedef struct packed {
        logic dp_voltage_source_en;
        logic dm_voltage_source_en;
        logic dp_sink_en;
        logic dm_sink_en;
        logic dp_current_source_en;
        logic dm_current_source_en;
        logic comparator_on_dm;
    } analog_ctrl_s;

    localparam analog_ctrl_s ANALOG_CTRL_RESET = '0;

    // asynchronous inputs passed through the two-stage synchroniser
    typedef struct packed {
        logic link_clk;
        logic stop;
        logic [7:0] data;
        logic [1:0] line_state;
        logic comparator;
    } pin_sample_s;

    localparam int PIN_SAMPLE_W = $bits(pin_sample_s);

endpackage

// *** rtl/pin_sync2.sv ***
// two flip-flop synchroniser for a bundle of asynchronous inputs
`timescale 1ns/100ps
module pin_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    initial begin
        if (WIDTH < 1) begin
            $error("pin_sync2: WIDTH must be at least 1");
        end
    end

    logic [WIDTH-1:0] stage1;

    // stage1 feeds only the second stage
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// *** rtl/charger_detect_id_sense_regs.sv ***
// charger detect, headset audio key and id-resistor measurement registers behind a ulpi register port
// Function
// - charger control: three enables, reset zero
// - sink disabled forces comparator result zero
// - bit 3 selects device or charging-host role
// - host role swaps dp/dm analog connections
// - bit 4 reports comparator and se0 line
// - comparator result mirrored to carkit status
// - audio mode only while key is 1010
// - id register read 36-38, write/set/clear
// - bits 2:0 hold measured resistance code
// - done bit set after 282 us measurement
// - reading code here clears done
// - carkit read of code keeps done
// - setting bit 4 starts a measurement
// - start bit clears when measurement completes
// - enabled done raises rxcmd alt_int
// - effective enable ORs carkit enable bit
// - vendor range uses ulpi immediate accesses
// - enabled done rise sets carkit latch
`timescale 1ns/100ps
module charger_detect_id_sense_regs #(
    parameter int MEASURE_CYCLES = charger_id_pkg::ID_MEASURE_CYCLES
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ulpi_clk,
    input wire logic ulpi_stp,
    input wire logic [7:0] ulpi_data_in,
    output logic [7:0] ulpi_data_out,
    output logic ulpi_data_oe_n,
    output logic ulpi_dir,
    output logic ulpi_nxt,
    input wire logic [1:0] line_state,
    input wire logic comparator_raw,
    input wire logic [2:0] id_converter_code,
    input wire logic carkit_irq_enable,
    input wire logic carkit_latch_read,
    output charger_id_pkg::analog_ctrl_s analog_ctrl,
    output logic data_voltage_seen,
    output logic headset_audio_mode,
    output logic id_converter_run,
    output logic [2:0] id_resistance_code,
    output logic id_measure_done,
    output logic id_done_latch
);
    initial begin
        if (MEASURE_CYCLES < 2) begin
            $error("charger_detect_id_sense_regs: MEASURE_CYCLES must be at least 2");
        end
    end

    localparam int CNT_W = $clog2(MEASURE_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(MEASURE_CYCLES - 1);

    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_WR_DATA = 7'b0000010,
        ST_WR_STOP = 7'b0000100,
        ST_RD_TURN = 7'b0001000,
        ST_RD_DATA = 7'b0010000,
        ST_TURN_BACK = 7'b0100000,
        ST_RX_DATA = 7'b1000000
    } ulpi_state_e;

    charger_id_pkg::pin_sample_s pin_async;
    charger_id_pkg::pin_sample_s pin;
    ulpi_state_e state;
    logic link_clk_prev;
    logic link_rise;
    logic [5:0] reg_addr;
    logic [7:0] wr_byte;
    logic wr_commit;
    logic rd_take;
    logic [7:0] rd_value;
    logic [3:0] charger_ctrl;
    logic [3:0] audio_key;
    logic [7:0] id_ctrl;
    logic [7:0] next_id_ctrl;
    logic [CNT_W-1:0] measure_cnt;
    logic measure_end;
    logic done_clear;
    logic done_rise;
    logic irq_enable;
    logic alt_int_pending;
    logic comparator_live;

    assign pin_async = '{link_clk: ulpi_clk, stop: ulpi_stp, data: ulpi_data_in,
                         line_state: line_state, comparator: comparator_raw};

    pin_sync2 #(
        .WIDTH(charger_id_pkg::PIN_SAMPLE_W)
    ) u_pin_sync (
        .mclk(mclk),
        .resetn(resetn),
        .async_in(pin_async),
        .sync_out(pin)
    );

    // the link clock is only sampled; every ulpi step happens on its detected rising edge
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            link_clk_prev <= 1'b0;
        end else begin
            link_clk_prev <= pin.link_clk;
        end
    end

    assign link_rise = pin.link_clk & ~link_clk_prev;
    assign wr_commit = link_rise && state == ST_WR_STOP && pin.stop;
    assign rd_take = link_rise && state == ST_RD_TURN;

    // ulpi immediate register access and rxcmd sequencer
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            reg_addr <= 6'h00;
            wr_byte <= 8'h00;
            ulpi_nxt <= 1'b0;
            ulpi_dir <= 1'b0;
            ulpi_data_oe_n <= 1'b1;
            ulpi_data_out <= 8'h00;
        end else if (link_rise) begin
            case (state)
                ST_IDLE: begin
                    // a link command wins over a pending rxcmd
                    if (pin.data[charger_id_pkg::CMD_CODE_MSB:charger_id_pkg::CMD_CODE_LSB]
                        == charger_id_pkg::CMD_REG_WRITE) begin
                        reg_addr <= pin.data[charger_id_pkg::CMD_ADDR_MSB:0];
                        ulpi_nxt <= 1'b1;
                        state <= ST_WR_DATA;
                    end else if (pin.data[charger_id_pkg::CMD_CODE_MSB:charger_id_pkg::CMD_CODE_LSB]
                        == charger_id_pkg::CMD_REG_READ) begin
                        reg_addr <= pin.data[charger_id_pkg::CMD_ADDR_MSB:0];
                        ulpi_nxt <= 1'b1;
                        state <= ST_RD_TURN;
                    end else if (alt_int_pending) begin
                        ulpi_dir <= 1'b1;
                        state <= ST_RX_DATA;
                    end
                end
                ST_WR_DATA: begin
                    wr_byte <= pin.data;
                    ulpi_nxt <= 1'b0;
                    state <= ST_WR_STOP;
                end
                ST_WR_STOP: begin
                    if (pin.stop) begin
                        state <= ST_IDLE;
                    end
                end
                ST_RD_TURN: begin
                    ulpi_nxt <= 1'b0;
                    ulpi_dir <= 1'b1;
                    ulpi_data_out <= rd_value;
                    state <= ST_RD_DATA;
                end
                ST_RD_DATA: begin
                    ulpi_data_oe_n <= 1'b0;
                    state <= ST_TURN_BACK;
                end
                ST_RX_DATA: begin
                    ulpi_data_out <= {1'b1, 5'h00, pin.line_state};
                    ulpi_data_oe_n <= 1'b0;
                    state <= ST_TURN_BACK;
                end
                ST_TURN_BACK: begin
                    ulpi_data_oe_n <= 1'b1;
                    ulpi_dir <= 1'b0;
                    state <= ST_IDLE;
                end
                default: begin
                    ulpi_nxt <= 1'b0;
                    ulpi_dir <= 1'b0;
                    ulpi_data_oe_n <= 1'b1;
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // read data; unmapped addresses read zero
    always_comb begin
        rd_value = 8'h00;
        case (reg_addr)
            charger_id_pkg::CHARGER_DETECT_CONTROL: begin
                rd_value = {3'h0, data_voltage_seen, charger_ctrl};
            end
            charger_id_pkg::HEADSET_AUDIO_CONTROL: begin
                rd_value = {4'h0, audio_key};
            end
            charger_id_pkg::ID_RESISTOR_MEASURE, charger_id_pkg::ID_RESISTOR_MEASURE_SET,
            charger_id_pkg::ID_RESISTOR_MEASURE_CLR: begin
                rd_value = {1'b0, id_ctrl[6:0]};
            end
            default: begin
                rd_value = 8'h00;
            end
        endcase
    end

    // charger detect control
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            charger_ctrl <= charger_id_pkg::CHARGER_RESET;
        end else if (wr_commit && reg_addr == charger_id_pkg::CHARGER_DETECT_CONTROL) begin
            charger_ctrl <= wr_byte[charger_id_pkg::CHARGER_RW_MSB:0];
        end
    end

    // dp/dm routing of the detection sources; registered so outputs come from flops
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            analog_ctrl <= charger_id_pkg::ANALOG_CTRL_RESET;
        end else begin
            analog_ctrl.dp_voltage_source_en <= charger_ctrl[charger_id_pkg::DATA_VOLTAGE_SOURCE_EN_BIT]
                & ~charger_ctrl[charger_id_pkg::CHARGING_HOST_ROLE_BIT];
            analog_ctrl.dm_voltage_source_en <= charger_ctrl[charger_id_pkg::DATA_VOLTAGE_SOURCE_EN_BIT]
                & charger_ctrl[charger_id_pkg::CHARGING_HOST_ROLE_BIT];
            // the sink sits on the same line as the comparator
            analog_ctrl.dp_sink_en <= charger_ctrl[charger_id_pkg::DATA_SINK_COMPARATOR_EN_BIT]
                & ~charger_ctrl[charger_id_pkg::CHARGING_HOST_ROLE_BIT];
            analog_ctrl.dm_sink_en <= charger_ctrl[charger_id_pkg::DATA_SINK_COMPARATOR_EN_BIT]
                & charger_ctrl[charger_id_pkg::CHARGING_HOST_ROLE_BIT];
            analog_ctrl.dp_current_source_en <= charger_ctrl[charger_id_pkg::DP_SOURCE_CURRENT_EN_BIT]
                & ~charger_ctrl[charger_id_pkg::CHARGING_HOST_ROLE_BIT];
            analog_ctrl.dm_current_source_en <= charger_ctrl[charger_id_pkg::DP_SOURCE_CURRENT_EN_BIT]
                & charger_ctrl[charger_id_pkg::CHARGING_HOST_ROLE_BIT];
            // device role senses dp, host role senses dm
            analog_ctrl.comparator_on_dm <= charger_ctrl[charger_id_pkg::CHARGING_HOST_ROLE_BIT];
        end
    end

    // comparator result, gated by its enable and the se0 line state
    assign comparator_live = pin.comparator & charger_ctrl[charger_id_pkg::DATA_SINK_COMPARATOR_EN_BIT];

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            data_voltage_seen <= 1'b0;
        end else begin
            // also feeds the carkit status mirror
            data_voltage_seen <= comparator_live && pin.line_state == charger_id_pkg::LINE_STATE_SE0;
        end
    end

    // headset audio key
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            audio_key <= charger_id_pkg::AUDIO_RESET;
            headset_audio_mode <= 1'b0;
        end else begin
            if (wr_commit && reg_addr == charger_id_pkg::HEADSET_AUDIO_CONTROL) begin
                audio_key <= wr_byte[charger_id_pkg::AUDIO_KEY_MSB:0];
            end
            headset_audio_mode <= audio_key == charger_id_pkg::AUDIO_MODE_KEY;
        end
    end

    // id measurement control register: write, set and clear views
    assign measure_end = id_ctrl[charger_id_pkg::ID_MEASURE_GO_BIT] && measure_cnt == CNT_LAST;
    assign done_clear = rd_take && (reg_addr == charger_id_pkg::ID_RESISTOR_MEASURE
        || reg_addr == charger_id_pkg::ID_RESISTOR_MEASURE_SET
        || reg_addr == charger_id_pkg::ID_RESISTOR_MEASURE_CLR);

    always_comb begin
        next_id_ctrl = id_ctrl;
        if (wr_commit) begin
            case (reg_addr)
                charger_id_pkg::ID_RESISTOR_MEASURE: begin
                    next_id_ctrl[charger_id_pkg::ID_CODE_MSB:0] = wr_byte[charger_id_pkg::ID_CODE_MSB:0];
                    next_id_ctrl[6:4] = wr_byte[6:4];
                end
                charger_id_pkg::ID_RESISTOR_MEASURE_SET: begin
                    next_id_ctrl = id_ctrl | (wr_byte & charger_id_pkg::ID_SC_MASK);
                end
                charger_id_pkg::ID_RESISTOR_MEASURE_CLR: begin
                    next_id_ctrl = id_ctrl & ~(wr_byte & charger_id_pkg::ID_SC_MASK);
                end
                default: begin
                    next_id_ctrl = id_ctrl;
                end
            endcase
        end
        if (done_clear) begin
            next_id_ctrl[charger_id_pkg::ID_MEASURE_DONE_BIT] = 1'b0;
        end
        if (measure_end) begin
            // completion wins over a clear or a read in the same cycle
            next_id_ctrl[charger_id_pkg::ID_CODE_MSB:0] = id_converter_code;
            next_id_ctrl[charger_id_pkg::ID_MEASURE_DONE_BIT] = 1'b1;
            next_id_ctrl[charger_id_pkg::ID_MEASURE_GO_BIT] = 1'b0;
        end
        next_id_ctrl[7] = 1'b0;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            id_ctrl <= {5'h00, charger_id_pkg::ID_CODE_RESET};
        end else begin
            id_ctrl <= next_id_ctrl;
        end
    end

    // measurement timer runs while the start bit is held; clearing it aborts
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            measure_cnt <= '0;
        end else if (!id_ctrl[charger_id_pkg::ID_MEASURE_GO_BIT] || measure_end) begin
            measure_cnt <= '0;
        end else begin
            measure_cnt <= measure_cnt + CNT_W'(1);
        end
    end

    // interrupt and latch on the rising edge of done
    assign irq_enable = id_ctrl[charger_id_pkg::ID_DONE_IRQ_ENABLE_BIT] | carkit_irq_enable;
    assign done_rise = measure_end && !id_ctrl[charger_id_pkg::ID_MEASURE_DONE_BIT];

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            alt_int_pending <= 1'b0;
        end else if (done_rise && irq_enable) begin
            alt_int_pending <= 1'b1;
        end else if (link_rise && state == ST_RX_DATA) begin
            alt_int_pending <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            id_done_latch <= 1'b0;
        end else if (done_rise && irq_enable) begin
            id_done_latch <= 1'b1;
        end else if (carkit_latch_read) begin
            id_done_latch <= 1'b0;
        end
    end

    // mirrors for the carkit status registers and the analog converter
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            id_resistance_code <= charger_id_pkg::ID_CODE_RESET;
            id_measure_done <= 1'b0;
            id_converter_run <= 1'b0;
        end else begin
            id_resistance_code <= id_ctrl[charger_id_pkg::ID_CODE_MSB:0];
            id_measure_done <= id_ctrl[charger_id_pkg::ID_MEASURE_DONE_BIT];
            id_converter_run <= id_ctrl[charger_id_pkg::ID_MEASURE_GO_BIT];
        end
    end
endmodule

// *** sim/charger_id_asserts.sv ***
// checker for the charger/id register block, bound to its ports
`timescale 1ns/100ps
module charger_id_asserts #(
    parameter int MEASURE_CYCLES = charger_id_pkg::ID_MEASURE_CYCLES
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [7:0] ulpi_data_out,
    input wire logic ulpi_data_oe_n,
    input wire logic ulpi_dir,
    input wire logic [1:0] line_state,
    input wire logic carkit_irq_enable,
    input wire charger_id_pkg::analog_ctrl_s analog_ctrl,
    input wire logic data_voltage_seen,
    input wire logic id_converter_run,
    input wire logic id_measure_done,
    input wire logic id_done_latch
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    int run_count;
    // length of the current run; the check allows one cycle either way for the start edge
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            run_count <= 0;
        end else begin
            run_count <= id_converter_run ? run_count + 1 : 0;
        end
    end
    property p_sink_off;
        !(analog_ctrl.dp_sink_en || analog_ctrl.dm_sink_en) [*3] |-> !data_voltage_seen;
    endproperty
    a_sink_off: assert property (p_sink_off) else $error("seen flag high with sink off");
    property p_line_busy;
        (line_state != 2'h0) [*5] |-> !data_voltage_seen;
    endproperty
    a_line_busy: assert property (p_line_busy) else $error("seen flag high off se0");
    property p_role_swap;
        analog_ctrl.comparator_on_dm |-> !(analog_ctrl.dp_voltage_source_en || analog_ctrl.dp_sink_en);
    endproperty
    a_role_swap: assert property (p_role_swap) else $error("dp switch on in host role");
    property p_run_length;
        $rose(id_measure_done) |-> run_count >= MEASURE_CYCLES - 1 && run_count <= MEASURE_CYCLES + 1;
    endproperty
    a_run_length: assert property (p_run_length) else $error("measurement length wrong");
    property p_go_clears;
        $rose(id_measure_done) |-> !id_converter_run;
    endproperty
    a_go_clears: assert property (p_go_clears) else $error("start bit kept after done");
    property p_alt_int;
        $rose(id_measure_done) && carkit_irq_enable |-> ##[1:40] (!ulpi_data_oe_n && ulpi_data_out[7]);
    endproperty
    a_alt_int: assert property (p_alt_int) else $error("no alt_int status byte");
    property p_latch_set;
        $rose(id_measure_done) && carkit_irq_enable |-> ##[0:1] id_done_latch;
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("done latch not set");
    property p_oe_dir;
        !ulpi_data_oe_n |-> ulpi_dir;
    endproperty
    a_oe_dir: assert property (p_oe_dir) else $error("bus driven without dir");
endmodule

bind charger_detect_id_sense_regs charger_id_asserts #(.MEASURE_CYCLES(MEASURE_CYCLES)) u_chk (.*);

// *** sim/ulpi_link_model.sv ***
// link-side model: free-running link clock and ulpi immediate register accesses
`timescale 1ns/100ps
module ulpi_link_model (
    output logic ulpi_clk,
    output logic ulpi_stp,
    output logic [7:0] ulpi_data_in,
    input wire logic [7:0] ulpi_data_out,
    input wire logic ulpi_data_oe_n,
    input wire logic ulpi_dir,
    input wire logic ulpi_nxt
);
    logic [7:0] link_d;
    // the link drives the bus whenever the device does not; 00 is the idle no-op
    assign ulpi_data_in = ulpi_data_oe_n ? link_d : ulpi_data_out;
    // start offset keeps link edges clear of mclk edges
    initial begin
        ulpi_clk = 1'b0;
        ulpi_stp = 1'b0;
        link_d = 8'h00;
        #7;
        forever #80 ulpi_clk = ~ulpi_clk;
    end
    task automatic access(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd, output bit ok);
        ok = 1'b0;
        rd = 8'h00;
        @(posedge ulpi_clk);
        link_d <= cmd;
        for (int n = 0; n < 6 && !ok; n++) begin
            @(posedge ulpi_clk);
            ok = ulpi_nxt;
        end
        if (ok && !cmd[6]) begin
            link_d <= wd;
            @(posedge ulpi_clk);
            ulpi_stp <= 1'b1;
            // back to idle, so a stale data byte is never taken as a new command
            link_d <= 8'h00;
            @(posedge ulpi_clk);
            ulpi_stp <= 1'b0;
        end else if (ok) begin
            link_d <= ~cmd;
            ok = 1'b0;
            for (int n = 0; n < 6 && !ok; n++) begin
                @(posedge ulpi_clk);
                ok = ulpi_dir && !ulpi_data_oe_n;
                rd = ulpi_data_out;
            end
        end
        @(posedge ulpi_clk);
    endtask
    task automatic wait_rx(output logic [7:0] rx, output bit seen);
        seen = 1'b0;
        rx = 8'h00;
        for (int n = 0; n < 12 && !seen; n++) begin
            @(posedge ulpi_clk);
            seen = ulpi_dir && !ulpi_data_oe_n;
            rx = ulpi_data_out;
        end
        repeat (2) @(posedge ulpi_clk);
    endtask
endmodule

// *** sim/test_charger_detect_id_sense_regs.sv ***
// bench: register accesses over ulpi to the charger, audio key and id measurement registers
`timescale 1ns/100ps
module test_charger_detect_id_sense_regs;
    localparam logic [5:0] CHG = charger_id_pkg::CHARGER_DETECT_CONTROL;
    localparam logic [5:0] AUD = charger_id_pkg::HEADSET_AUDIO_CONTROL;
    localparam logic [5:0] IDR = charger_id_pkg::ID_RESISTOR_MEASURE;
    localparam logic [5:0] IDS = charger_id_pkg::ID_RESISTOR_MEASURE_SET;
    localparam logic [5:0] IDC = charger_id_pkg::ID_RESISTOR_MEASURE_CLR;
    logic mclk, resetn, ulpi_clk, ulpi_stp, ulpi_data_oe_n, ulpi_dir, ulpi_nxt, comparator_raw;
    logic carkit_irq_enable, carkit_latch_read, data_voltage_seen, headset_audio_mode;
    logic id_converter_run, id_measure_done, id_done_latch;
    logic [7:0] ulpi_data_in, ulpi_data_out, rd, rx;
    logic [1:0] line_state;
    logic [2:0] id_converter_code, id_resistance_code;
    logic [2:0] codes [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
    charger_id_pkg::analog_ctrl_s analog_ctrl;
    int bad_count = 0;
    int comparisons = 0;
    bit ok;
    bit seen;
    // short measurement keeps the run brief
    charger_detect_id_sense_regs #(.MEASURE_CYCLES(20)) DUT (.*);
    ulpi_link_model link (.*);
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        if (bad_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic xfer(input logic [1:0] code, input logic [5:0] a, input logic [7:0] d);
        link.access({code, a}, d, rd, ok);
        if (!ok) begin
            bad_count++;
            stop_test();
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        xfer(charger_id_pkg::CMD_REG_WRITE, a, d);
    endtask
    task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
        xfer(charger_id_pkg::CMD_REG_READ, a, 8'h00);
        check(rd, exp);
    endtask
    // start a measurement, then look for the status byte and the latch, and clear the latch
    task automatic measure(input logic [5:0] a, input logic [7:0] d, input logic [2:0] c, input logic irq,
        input logic en);
        @(posedge mclk);
        id_converter_code <= c;
        carkit_irq_enable <= irq;
        wr(a, d);
        link.wait_rx(rx, seen);
        check({7'h00, seen}, {7'h00, en});
        if (en) begin
            check(rx, {1'b1, 5'h00, line_state});
        end
        check({7'h00, id_done_latch}, {7'h00, en});
        @(posedge mclk);
        carkit_latch_read <= 1'b1;
        @(posedge mclk);
        carkit_latch_read <= 1'b0;
        repeat (3) @(posedge mclk);
        check({6'h00, id_done_latch, id_measure_done}, 8'h01);
    endtask
    initial begin
        resetn = 1'b0;
        line_state = 2'h0;
        comparator_raw = 1'b1;
        id_converter_code = 3'h0;
        carkit_irq_enable = 1'b0;
        carkit_latch_read = 1'b0;
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        repeat (40) @(posedge mclk);
        check({1'b0, analog_ctrl}, 8'h00);
        rdc(CHG, 8'h00);
        rdc(AUD, 8'h00);
        rdc(IDC, 8'h00);
        wr(6'h3f, 8'hff);
        rdc(6'h3f, 8'h00);
        wr(CHG, 8'h07);
        rdc(CHG, 8'h17);
        check({1'b0, analog_ctrl}, 8'h54);
        check({7'h00, data_voltage_seen}, 8'h01);
        wr(CHG, 8'hff);
        rdc(CHG, 8'h1f);
        check({1'b0, analog_ctrl}, 8'h2b);
        @(posedge mclk);
        line_state <= 2'h1;
        rdc(CHG, 8'h0f);
        @(posedge mclk);
        line_state <= 2'h0;
        wr(CHG, 8'h01);
        rdc(CHG, 8'h01);
        check({7'h00, data_voltage_seen}, 8'h00);
        wr(CHG, 8'h00);
        check({1'b0, analog_ctrl}, 8'h00);
        wr(AUD, 8'hfa);
        rdc(AUD, 8'h0a);
        check({7'h00, headset_audio_mode}, 8'h01);
        wr(AUD, 8'h0b);
        check({7'h00, headset_audio_mode}, 8'h00);
        measure(IDR, 8'h50, codes[0], 1'b0, 1'b1);
        for (int i = 0; i < 7; i++) begin
            if (i > 0) begin
                measure(IDS, 8'h10, codes[i], 1'b0, 1'b1);
            end
            check({5'h00, id_resistance_code}, {5'h00, codes[i]});
            rdc(IDR, {5'h09, codes[i]});
            rdc(IDS, {5'h08, codes[i]});
        end
        wr(IDC, 8'h40);
        rdc(IDR, 8'h07);
        measure(IDS, 8'h10, 3'h7, 1'b1, 1'b1);
        // done must be low again, so the next run has a real rising edge with both enables off
        rdc(IDR, 8'h0f);
        measure(IDS, 8'h10, 3'h7, 1'b0, 1'b0);
        rdc(IDC, 8'h0f);
        stop_test();
    end
endmodule
